//--- ntrc_pkg.sv
// package of constants for the nine-track record check generator
// assumes one 10 MHz clock; consumers import the whole package
// ==========================================================
package ntrc_pkg;
	// ==========================================================
	// record and framing figures
	localparam int MIN_REC_CHARS = 18;
	localparam int MAX_REC_CHARS = 2048;
	localparam int REC_BLANKS = 3;
	localparam int EOF_BLANKS = 7;
	localparam logic [7:0] EOF_CHAR = 8'h9e; // octal 236
	localparam logic [8:0] CRC_CLEAR = 9'h000;
	localparam logic [8:0] LRC_CLEAR = 9'h000;
	// character vector layout: bit 8 is parity, bits 7..0 data
	localparam int PAR_POS = 8;
	// output enable mask: complement all but CRC2 and CRC4
	localparam logic [8:0] CRC_OUT_MASK = 9'h1eb;
	// feedback mask: bits 2..5 inverted on parity entry
	localparam logic [8:0] CRC_FB_MASK = 9'h03c;
	// gap lengths in character strobes
	localparam int GAP_STD_STROBES = 480; // 0.6 in at 800 cpi
	localparam int GAP_EXT_STROBES = 2400; // 3 in at 800 cpi
	// ==========================================================
	// sequencer states
	typedef enum logic [8:0] {
		ST_IDLE = 9'h001,
		ST_DATA = 9'h002,
		ST_BLK1 = 9'h004,
		ST_CRC = 9'h008,
		ST_BLK2 = 9'h010,
		ST_LRC = 9'h020,
		ST_GAP = 9'h040,
		ST_XGAP = 9'h080,
		ST_EOFC = 9'h100
	} ntrc_state_type;
endpackage

//--- ntrc_fifo.sv
// small data fifo between byte source and the check generator
// assumes one clock, synchronous inputs, active low async reset
`timescale 1ns/100ps
module ntrc_fifo #(
	parameter int WIDTH = 9,
	parameter int DEPTH = 4
) (
	input wire logic CLK,
	input wire logic RST_B,
	input wire logic CE,
	input wire logic [WIDTH-1:0] IN_DATA,
	input wire logic IN_VALID,
	output logic IN_READY,
	output logic [WIDTH-1:0] OUT_DATA,
	output logic OUT_VALID,
	input wire logic OUT_READY
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	// ==========================================================
	// elaboration check
	if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0)
		$error("fifo depth must be a power of two, at least 2");
	logic [WIDTH-1:0] mem_r [DEPTH]; // storage words
	logic [AW:0] wp_r; // write pointer with wrap bit
	logic [AW:0] rp_r; // read pointer with wrap bit
	logic push; // accepted write
	logic pop; // accepted read
	assign IN_READY = (wp_r - rp_r) != (AW + 1)'(DEPTH);
	assign OUT_VALID = wp_r != rp_r;
	assign push = CE && IN_VALID && IN_READY;
	assign pop = CE && OUT_VALID && OUT_READY;
	// read data straight from storage at the head
	assign OUT_DATA = mem_r[rp_r[AW-1:0]];
	// storage write, no reset needed for data
	always_ff @(posedge CLK)
	begin
		if (push)
			mem_r[wp_r[AW-1:0]] <= IN_DATA;
	end
	// pointers
	always_ff @(posedge CLK or negedge RST_B)
	begin
		if (!RST_B)
		begin
			wp_r <= '0;
			rp_r <= '0;
		end
		else
		begin
			if (push)
				wp_r <= wp_r + 1'b1;
			if (pop)
				rp_r <= rp_r + 1'b1;
		end
	end
endmodule

//--- ntrc_gen.sv
// nine-track record check generator: frames records and file marks
// assumes a character strobe per tape character period, one clock
`timescale 1ns/100ps
module ntrc_gen #(
	parameter int FIFO_DEPTH = 4,
	parameter int GAP_STD = ntrc_pkg::GAP_STD_STROBES,
	parameter int GAP_EXT = ntrc_pkg::GAP_EXT_STROBES
) (
	input wire logic CLK,
	input wire logic RST_B,
	input wire logic CE,
	input wire logic ODD_PARITY,
	input wire logic CHAR_STROBE,
	input wire logic REC_START,
	input wire logic FILE_MARK,
	input wire logic [7:0] BYTE_DATA,
	input wire logic BYTE_LAST,
	input wire logic BYTE_VALID,
	output logic BYTE_READY,
	output logic [8:0] TRACK_DATA,
	output logic WRITE_PULSE,
	output logic LRC_STROBE,
	output logic BUSY,
	output logic LEN_ERROR,
	output logic [8:0] LAST_CRC,
	output logic [8:0] LAST_LRC
);
	import ntrc_pkg::*;
	// ==========================================================
	// elaboration checks
	if (GAP_STD < 1 || GAP_EXT < GAP_STD)
		$error("gap lengths must be positive and extended not shorter");
	// the shared twelve-bit counter has to reach the longest gap
	if (GAP_EXT > 4096)
		$error("extended gap too long for the twelve-bit counter");
	ntrc_state_type state_r; // sequencer state
	ntrc_state_type state_nxt; // next sequencer state
	logic [8:0] crc_r; // cyclic check register
	logic [8:0] lrc_r; // longitudinal check register
	logic [11:0] cnt_r; // blank, gap and character count
	logic [11:0] cnt_nxt; // its next value
	logic fm_r; // current record is a file mark
	logic [8:0] char_vec; // character incl. parity, internal layout
	logic [8:0] fifo_data; // fifo head: last flag, byte
	logic fifo_valid; // fifo has a byte
	logic fifo_pop; // take the byte this strobe
	logic [8:0] crc_mix; // crc after xor of the character
	logic [8:0] crc_shift; // crc after shift and feedback
	logic [8:0] crc_char; // crc character as written
	logic [8:0] out_vec; // character to write this strobe
	logic do_write; // a character goes to tape this strobe
	logic step; // strobe with clock enable
	// ==========================================================
	// input buffer; stalls the source when four bytes wait
	ntrc_fifo #(
		.WIDTH(9),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.CLK(CLK),
		.RST_B(RST_B),
		.CE(CE),
		.IN_DATA({BYTE_LAST, BYTE_DATA}),
		.IN_VALID(BYTE_VALID),
		.IN_READY(BYTE_READY),
		.OUT_DATA(fifo_data),
		.OUT_VALID(fifo_valid),
		.OUT_READY(fifo_pop)
	);
	assign step = CE && CHAR_STROBE;
	// ==========================================================
	// character path
	// vertical parity, even or odd by the program setting
	function automatic logic [8:0] with_parity(input logic [7:0] b, input logic odd);
		logic p;
		p = (^b) ^ odd;
		return {p, b};
	endfunction
	// data byte with parity, one byte per tape character
	assign char_vec = with_parity(fifo_data[7:0], ODD_PARITY);
	// xor of all nine bits into the matching positions
	assign crc_mix = crc_r ^ char_vec;
	// circular right shift: parity <- 7, 7 <- 6 ... 0 <- parity
	// layout bit 8 = parity, bit k = data k; right shift moves k to k+1
	always_comb
	begin
		crc_shift = {crc_mix[7:0], crc_mix[8]};
		// parity entry is crc_mix[7]; invert 2..5 when it is a one
		if (crc_mix[7])
			crc_shift = crc_shift ^ CRC_FB_MASK;
	end
	// complement all but positions 2 and 4 at check time
	assign crc_char = crc_r ^ CRC_OUT_MASK;
	// choose the character written this strobe
	always_comb
	begin
		out_vec = '0;
		do_write = 1'b0;
		fifo_pop = 1'b0;
		unique case (state_r)
			ST_DATA:
			begin
				// underrun writes nothing and waits
				if (fifo_valid && step)
				begin
					out_vec = char_vec;
					do_write = 1'b1;
					fifo_pop = 1'b1;
				end
			end
			ST_EOFC:
			begin
				// file mark writes the eof character, parity per setting
				out_vec = with_parity(EOF_CHAR, ODD_PARITY);
				do_write = step;
			end
			ST_CRC:
			begin
				out_vec = crc_char;
				do_write = step;
			end
			default:
			begin
				out_vec = '0;
			end
		endcase
	end
	// ==========================================================
	// sequencer
	always_comb
	begin
		state_nxt = state_r;
		cnt_nxt = cnt_r;
		unique case (state_r)
			ST_IDLE:
			begin
				cnt_nxt = '0;
				if (CE && FILE_MARK)
				begin
					state_nxt = ST_XGAP;
				end
				else if (CE && REC_START)
					state_nxt = ST_DATA;
			end
			ST_XGAP:
			begin
				// extended blank gap ahead of the file mark
				if (step)
				begin
					cnt_nxt = cnt_r + 12'h001;
					if (cnt_r == 12'(GAP_EXT - 1))
					begin
						cnt_nxt = '0;
						state_nxt = ST_EOFC;
					end
				end
			end
			ST_EOFC:
			begin
				// a file mark skips the crc character and its blanks
				if (step)
					state_nxt = ST_BLK2;
			end
			ST_DATA:
			begin
				if (fifo_pop)
				begin
					cnt_nxt = cnt_r + 12'h001;
					if (fifo_data[8])
					begin
						cnt_nxt = '0;
						state_nxt = ST_BLK1;
					end
				end
			end
			ST_BLK1:
			begin
				// blank periods: strobes pass without a write
				if (step)
				begin
					cnt_nxt = cnt_r + 12'h001;
					if (cnt_r == 12'(REC_BLANKS - 1))
					begin
						cnt_nxt = '0;
						state_nxt = ST_CRC;
					end
				end
			end
			ST_CRC:
			begin
				if (step)
					state_nxt = ST_BLK2;
			end
			ST_BLK2:
			begin
				// file marks wait seven blanks, records three
				if (step)
				begin
					cnt_nxt = cnt_r + 12'h001;
					if (cnt_r == (fm_r ? 12'(EOF_BLANKS - 1) : 12'(REC_BLANKS - 1)))
					begin
						cnt_nxt = '0;
						state_nxt = ST_LRC;
					end
				end
			end
			ST_LRC:
			begin
				if (step)
					state_nxt = ST_GAP;
			end
			ST_GAP:
			begin
				// interrecord gap after the longitudinal character
				if (step)
				begin
					cnt_nxt = cnt_r + 12'h001;
					if (cnt_r == 12'(GAP_STD - 1))
					begin
						cnt_nxt = '0;
						state_nxt = ST_IDLE;
					end
				end
			end
		endcase
	end
	// state and count
	always_ff @(posedge CLK or negedge RST_B)
	begin
		if (!RST_B)
		begin
			state_r <= ST_IDLE;
			cnt_r <= '0;
		end
		else if (CE)
		begin
			state_r <= state_nxt;
			cnt_r <= cnt_nxt;
		end
	end
	// file mark flag, caught when a frame opens
	always_ff @(posedge CLK or negedge RST_B)
	begin
		if (!RST_B)
			fm_r <= 1'b0;
		else if (CE && state_r == ST_IDLE)
			fm_r <= FILE_MARK;
	end
	// ==========================================================
	// cyclic check register
	always_ff @(posedge CLK or negedge RST_B)
	begin
		if (!RST_B)
			crc_r <= CRC_CLEAR;
		else if (CE)
		begin
			if (state_r == ST_IDLE)
				crc_r <= CRC_CLEAR;
			else if (state_r == ST_DATA && fifo_pop)
				crc_r <= crc_shift;
			else if (state_r == ST_CRC && step)
				crc_r <= CRC_CLEAR;
			// eof record never touches the crc register
		end
	end
	// ==========================================================
	// longitudinal register, toggled by every written one
	always_ff @(posedge CLK or negedge RST_B)
	begin
		if (!RST_B)
			lrc_r <= LRC_CLEAR;
		else if (CE)
		begin
			if (state_r == ST_IDLE)
				lrc_r <= LRC_CLEAR;
			else if (do_write)
				lrc_r <= lrc_r ^ out_vec;
		end
	end
	// ==========================================================
	// tape side outputs, registered
	// the buffer image equals lrc_r, so the lrc strobe emits its set bits
	always_ff @(posedge CLK or negedge RST_B)
	begin
		if (!RST_B)
		begin
			TRACK_DATA <= '0;
			WRITE_PULSE <= 1'b0;
			LRC_STROBE <= 1'b0;
		end
		else if (CE)
		begin
			WRITE_PULSE <= do_write;
			LRC_STROBE <= 1'b0;
			if (do_write)
				TRACK_DATA <= out_vec;
			else if (state_r == ST_LRC && step)
			begin
				// parity bit included; evenness per track, crc included
				TRACK_DATA <= lrc_r;
				LRC_STROBE <= 1'b1;
			end
		end
	end
	// ==========================================================
	// status: record length check and last check characters
	always_ff @(posedge CLK or negedge RST_B)
	begin
		if (!RST_B)
		begin
			LEN_ERROR <= 1'b0;
			LAST_CRC <= '0;
			LAST_LRC <= '0;
		end
		else if (CE)
		begin
			if (state_r == ST_IDLE && REC_START)
				LEN_ERROR <= 1'b0;
			else if (state_r == ST_DATA && fifo_pop)
			begin
				// length outside 18..2048 flagged, record still framed
				if (fifo_data[8] && (cnt_r < 12'(MIN_REC_CHARS - 1)))
					LEN_ERROR <= 1'b1;
				if (cnt_r >= 12'(MAX_REC_CHARS))
					LEN_ERROR <= 1'b1;
			end
			// kept for the host to compare on reread
			if (state_r == ST_CRC && step)
				LAST_CRC <= crc_char;
			if (state_r == ST_LRC && step)
				LAST_LRC <= lrc_r;
		end
	end
	assign BUSY = state_r != ST_IDLE;
endmodule

//--- ntrc_gen_assertions.sv
// checker on the ports of the record check generator
// assumes one clock domain; bound to every ntrc_gen instance
`timescale 1ns/100ps
module ntrc_gen_assertions (
	input wire logic CLK,
	input wire logic RST_B,
	input wire logic CE,
	input wire logic CHAR_STROBE,
	input wire logic REC_START,
	input wire logic FILE_MARK,
	input wire logic BUSY,
	input wire logic [8:0] TRACK_DATA,
	input wire logic WRITE_PULSE,
	input wire logic LRC_STROBE,
	input wire logic [8:0] LAST_LRC,
	input wire logic [8:0] LAST_CRC
);
	// ==========================================================
	// helper state
	logic [8:0] acc_r; // xor of all characters of the record
	logic [11:0] gap_r; // strobes since the last write
	default clocking @(posedge CLK); endclocking
	default disable iff (!RST_B);
	sequence s_start;
		CE && !BUSY && (REC_START || FILE_MARK);
	endsequence
	// mirror the head buffer; a strobe with a pulse still counts
	always_ff @(posedge CLK or negedge RST_B)
	begin
		if (!RST_B)
		begin
			acc_r <= 9'h000;
			gap_r <= 12'h000;
		end
		else if (CE)
		begin
			acc_r <= LRC_STROBE ? 9'h000 : (WRITE_PULSE ? acc_r ^ TRACK_DATA : acc_r);
			gap_r <= (WRITE_PULSE ? 12'h000 : gap_r) + {11'h000, CHAR_STROBE};
		end
	end
	// ==========================================================
	// properties
	pulse_cause_a: assert property (WRITE_PULSE |-> $past(CE && CHAR_STROBE))
		else $error("write pulse without a character strobe");
	lrc_cause_a: assert property (LRC_STROBE |-> $past(CE && CHAR_STROBE))
		else $error("lrc strobe without a character strobe");
	strobe_excl_a: assert property (LRC_STROBE |-> !WRITE_PULSE)
		else $error("write pulse together with lrc strobe");
	write_busy_a: assert property (WRITE_PULSE || LRC_STROBE |-> BUSY)
		else $error("character written while idle");
	lrc_even_a: assert property (LRC_STROBE |-> TRACK_DATA == acc_r)
		else $error("lrc character leaves a track odd");
	lrc_blank_a: assert property (LRC_STROBE |-> gap_r == 12'd4 || gap_r == 12'd8)
		else $error("wrong blank count before lrc");
	lrc_kept_a: assert property (LRC_STROBE |=> LAST_LRC == $past(TRACK_DATA))
		else $error("last lrc not kept");
	start_busy_a: assert property (s_start |=> BUSY)
		else $error("record start not taken");
	track_hold_a: assert property ($changed(TRACK_DATA) |->
		WRITE_PULSE || LRC_STROBE || $past(LRC_STROBE))
		else $error("track data changed without a write");
	crc_kept_a: assert property ($changed(LAST_CRC) |-> WRITE_PULSE || $past(WRITE_PULSE))
		else $error("last crc changed without a write");
endmodule
bind ntrc_gen ntrc_gen_assertions ntrc_gen_assertions_inst (.CLK(CLK), .RST_B(RST_B),
	.CE(CE), .CHAR_STROBE(CHAR_STROBE), .REC_START(REC_START), .FILE_MARK(FILE_MARK),
	.BUSY(BUSY), .TRACK_DATA(TRACK_DATA), .WRITE_PULSE(WRITE_PULSE),
	.LRC_STROBE(LRC_STROBE), .LAST_LRC(LAST_LRC), .LAST_CRC(LAST_CRC));

//--- ntrc_tape_model.sv
// behavioural write buffer and heads of the tape transport
// assumes one character per write pulse from the generator
`timescale 1ns/100ps
module ntrc_tape_model (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic [8:0] track_data,
	input wire logic write_pulse,
	input wire logic lrc_strobe,
	output logic [8:0] tape_lrc_r
);
	// ==========================================================
	// write buffer
	logic [8:0] wbuf_r; // one flip-flop per head
	// each one flips its head; the strobe writes then clears
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			wbuf_r <= 9'h000;
			tape_lrc_r <= 9'h000;
		end
		else if (lrc_strobe)
		begin
			tape_lrc_r <= wbuf_r;
			wbuf_r <= 9'h000;
		end
		else if (write_pulse)
			wbuf_r <= wbuf_r ^ track_data;
	end
endmodule

//--- test_nine_track_record_check_gen.sv
// self-checking bench: random records, boundary lengths, file marks
// assumes ntrc_pkg, ntrc_fifo, ntrc_gen and the tape model compiled
`timescale 1ns/100ps
module test_nine_track_record_check_gen;
	import ntrc_pkg::*;
	// ==========================================================
	// signals
	logic clk = 1'b0;
	logic rst_b = 1'b0;
	logic odd_parity = 1'b1;
	logic ce = 1'b1; // clock enable, dropped once while idle
	logic char_strobe = 1'b0;
	logic rec_start = 1'b0;
	logic file_mark = 1'b0;
	logic [7:0] byte_data = 8'h00;
	logic byte_last = 1'b0;
	logic byte_valid = 1'b0;
	logic byte_ready, write_pulse, lrc_strobe, busy, len_error;
	logic [8:0] track_data, last_crc, last_lrc, tape_lrc, lrc_v;
	logic [8:0] wq[$]; // characters seen at the heads
	int ws[$]; // strobe index of each character
	int sc = 0;
	int lrc_s = 0;
	int errors = 0;
	int n_tests = 0;
	int seed = 32'hdb6449e6;
	logic [2:0] ph = 3'h0; // strobe phase
	always #50 clk = ~clk;
	ntrc_gen #(.GAP_STD(4), .GAP_EXT(8)) ntrc_gen_inst (.CLK(clk), .RST_B(rst_b), .CE(ce),
		.ODD_PARITY(odd_parity), .CHAR_STROBE(char_strobe), .REC_START(rec_start),
		.FILE_MARK(file_mark), .BYTE_DATA(byte_data), .BYTE_LAST(byte_last),
		.BYTE_VALID(byte_valid), .BYTE_READY(byte_ready), .TRACK_DATA(track_data),
		.WRITE_PULSE(write_pulse), .LRC_STROBE(lrc_strobe), .BUSY(busy),
		.LEN_ERROR(len_error), .LAST_CRC(last_crc), .LAST_LRC(last_lrc));
	ntrc_tape_model ntrc_tape_model_inst (.clk(clk), .rst_b(rst_b), .track_data(track_data),
		.write_pulse(write_pulse), .lrc_strobe(lrc_strobe), .tape_lrc_r(tape_lrc));
	// one character period every eight clocks, slower than the fifo
	always @(posedge clk)
	begin
		ph <= ph + 3'h1;
		char_strobe <= (ph == 3'h7);
	end
	// log every character and the lrc with its strobe index
	always @(posedge clk)
	begin
		if (char_strobe)
			sc = sc + 1;
		if (write_pulse)
		begin
			wq.push_back(track_data);
			ws.push_back(sc);
		end
		if (lrc_strobe)
		begin
			lrc_v = track_data;
			lrc_s = sc;
		end
	end
	// ==========================================================
	// expectation helpers
	function automatic logic [8:0] chr(input logic [7:0] b);
		return {odd_parity ? ~^b : ^b, b};
	endfunction
	function automatic logic [8:0] crc_step(input logic [8:0] c, input logic [8:0] ch);
		logic [8:0] x;
		x = c ^ ch;
		return {x[7:0], x[8]} ^ (x[7] ? CRC_FB_MASK : 9'h000);
	endfunction
	task automatic chk(input string what, input logic [8:0] exp, input logic [8:0] got);
		n_tests++;
		if (got !== exp)
		begin
			errors++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic chkn(input string what, input int exp, input int got);
		n_tests++;
		if (got != exp)
		begin
			errors++;
			$display("ERROR %s expected %0d seen %0d", what, exp, got);
		end
	endtask
	task automatic results;
		$display("comparisons %0d mismatches %0d", n_tests, errors);
		if (errors == 0 && n_tests > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	// bounded wait; running out ends the run
	task automatic limit(input int t, input int lim);
		if (t >= lim)
		begin
			errors++;
			results();
		end
	endtask
	// ==========================================================
	// one record or file mark, then its checks
	task automatic run_rec(input int n, input bit fm);
		logic [7:0] b[$];
		logic [8:0] crc, lrc;
		int i, t;
		crc = CRC_CLEAR;
		lrc = LRC_CLEAR;
		lrc_v = 'x;
		wq.delete();
		ws.delete();
		for (i = 0; i < n; i++)
			b.push_back(fm ? EOF_CHAR : (i == 0 ? 8'h00 : 8'($random(seed))));
		@(posedge clk);
		rec_start <= !fm;
		file_mark <= fm;
		@(posedge clk);
		rec_start <= 1'b0;
		file_mark <= 1'b0;
		// keep the fifo full; it refuses while four bytes wait
		for (i = 0; i < n && !fm; i++)
		begin
			byte_data <= b[i];
			byte_last <= (i == n - 1);
			byte_valid <= 1'b1;
			t = 0;
			do
			begin
				@(posedge clk);
				t++;
			end
			while (byte_ready !== 1'b1 && t < 100);
			limit(t, 100);
		end
		byte_valid <= 1'b0;
		byte_last <= 1'b0;
		t = 0;
		do
		begin
			@(posedge clk);
			t++;
		end
		while (busy !== 1'b0 && t < 30000);
		limit(t, 30000);
		for (i = 0; i < n; i++)
		begin
			chk("character", chr(b[i]), wq[i]);
			crc = crc_step(crc, chr(b[i]));
			lrc = lrc ^ chr(b[i]);
		end
		crc = crc ^ CRC_OUT_MASK;
		if (!fm)
		begin
			chk("crc character", crc, wq[n]);
			chk("last crc", crc, last_crc);
			chk("len error", {8'h00, (n < 18 || n > 2048)}, {8'h00, len_error});
			chkn("crc blanks", 4, ws[n] - ws[n-1]);
			lrc = lrc ^ crc;
		end
		else
			chk("eof lrc", chr(EOF_CHAR), lrc_v);
		chkn("characters", n + 32'(!fm), wq.size());
		chkn("lrc blanks", fm ? 8 : 4, lrc_s - ws[wq.size() - 1]);
		chk("lrc character", lrc, lrc_v);
		chk("tape lrc", lrc, tape_lrc);
		chk("last lrc", lrc, last_lrc);
	endtask
	// ==========================================================
	// main sequence: both parities, boundary and random lengths
	initial
	begin
		repeat (8) @(posedge clk);
		rst_b <= 1'b1;
		// outputs right after reset, then a start that a frozen block ignores
		@(posedge clk);
		chk("reset track", 9'h000, track_data);
		chk("reset crc", CRC_CLEAR, last_crc);
		chk("reset lrc", LRC_CLEAR, last_lrc);
		chk("reset busy", 9'h000, {8'h00, busy});
		chk("reset ready", 9'h001, {8'h00, byte_ready});
		ce <= 1'b0;
		rec_start <= 1'b1;
		repeat (2) @(posedge clk);
		chk("frozen busy", 9'h000, {8'h00, busy});
		rec_start <= 1'b0;
		ce <= 1'b1;
		for (int p = 0; p < 2; p++)
		begin
			odd_parity <= (p == 1);
			run_rec(18, 1'b0);
			run_rec(17, 1'b0);
			run_rec(19 + ($random(seed) & 31), 1'b0);
			run_rec(1, 1'b1);
		end
		run_rec(2048, 1'b0);
		// one byte too many: still framed, length flagged
		run_rec(2049, 1'b0);
		results();
	end
endmodule
